// ### design/dpd_pkg.sv
package dpd_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_CH0_LO = 3'h1;
   localparam logic [2:0] ADDR_CH0_HI = 3'h2;
   localparam logic [2:0] ADDR_CH1_LO = 3'h3;
   localparam logic [2:0] ADDR_CH1_HI = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;
   localparam logic [2:0] ADDR_COUNT = 3'h6;

   // ----------------------------------------------------------------
   // control fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DIV_LSB = 3;
   localparam logic [7:0] CTRL_RESET = 8'h07;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // divider terminal counts (divide by 1, 4, 16, 64)
   // ----------------------------------------------------------------
   localparam logic [5:0] DIV1_LAST = 6'h00;
   localparam logic [5:0] DIV4_LAST = 6'h03;
   localparam logic [5:0] DIV16_LAST = 6'h0F;
   localparam logic [5:0] DIV64_LAST = 6'h3F;
   localparam logic [7:0] BYTE_LAST = 8'hFF;
   localparam logic [15:0] WORD_LAST = 16'hFFFF;

   typedef enum logic [2:0] {
      MODE_OFF,
      MODE_SINGLE16,
      MODE_DUAL8,
      MODE_DUAL16,
      MODE_SD_NRZ,
      MODE_INDEP8,
      MODE_SD_RZ,
      MODE_DISABLED
   } dpd_mode_t;

   typedef struct packed {
      logic [2:0] spare;
      logic [1:0] div;
      dpd_mode_t mode;
   } dpd_ctrl_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } dpd_word_t;

endpackage

// ### design/dpd_sd_chan.sv
`timescale 1ns/1ps
`default_nettype none
module dpd_sd_chan
   import dpd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic tick,
   input wire logic clear,
   input wire dpd_word_t value,
   // bitstream
   output logic bit_out
);

   logic [15:0] acc_r;
   logic [15:0] acc_nxt;
   logic bit_r;
   logic bit_nxt;
   logic [16:0] sum;

   // first-order accumulator: carry density is value/65536
   always_comb begin
      sum = {1'b0, acc_r} + {1'b0, value};
      acc_nxt = acc_r;
      bit_nxt = bit_r;
      if (clear) begin
         acc_nxt = 16'h0000;
         bit_nxt = 1'b0;
      end else if (tick) begin
         acc_nxt = sum[15:0]; // R10
         bit_nxt = sum[16]; // R8
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 16'h0000;
         bit_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         bit_r <= bit_nxt;
      end
   end

   assign bit_out = bit_r;

endmodule
`default_nettype wire

// ### design/dpd_top.sv
// Summary of operation
// [R1] six modulator modes exist, two of them 16-bit sigma-delta outputs.
// [R2] the control register picks mode and clock divider; data registers set duty.
// [R3] any control write restarts the modulator counter.
// [R4] in 16-bit modes a low-byte write only fills a hidden holding byte.
// [R5] a high-byte write updates the word, which takes effect at the next cycle.
// [R6] software writes control first, then low byte before high byte.
// [R7] mode 5 gives two independent 8-bit pulse outputs.
// [R8] mode 6 is return-to-zero sigma-delta, mode 4 the same in non-return-to-zero.
// [R9] software should use divider 4 with the return-to-zero mode.
// [R10] each return-to-zero one is half a tick high, pattern repeats every 65536 ticks.
// [R11] software may trade resolution for speed by padding low bits with 0...01.
// [R12] in mode 5 channel 1 bytes set the periods and channel 0 bytes the duties.
// [R13] both outputs share one clock source and one divider.
// [R14] mode 7 releases both pins to ordinary port use.
// [R15] mode lives in control bits 2:0 and divider select in bits 4:3.
// [R16] the counter steps once per divided clock; a cycle ends when it wraps.
`timescale 1ns/1ps
`default_nettype none
module dpd_top
   import dpd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // modulator pins
   output logic out_a,
   output logic out_a_oe,
   output logic out_b,
   output logic out_b_oe
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   dpd_ctrl_t ctrl_r;
   dpd_ctrl_t ctrl_nxt;
   dpd_word_t vis0_r;
   dpd_word_t vis0_nxt;
   dpd_word_t vis1_r;
   dpd_word_t vis1_nxt;
   logic [7:0] hold0_r;
   logic [7:0] hold0_nxt;
   logic [7:0] hold1_r;
   logic [7:0] hold1_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   dpd_word_t act0_r;
   dpd_word_t act0_nxt;
   dpd_word_t act1_r;
   dpd_word_t act1_nxt;
   logic [5:0] presc_r;
   logic [5:0] presc_nxt;
   logic [15:0] cnt_a_r;
   logic [15:0] cnt_a_nxt;
   logic [7:0] cnt_b_r;
   logic [7:0] cnt_b_nxt;
   logic out_a_r;
   logic out_a_nxt;
   logic out_b_r;
   logic out_b_nxt;
   logic oe_r;
   logic oe_nxt;
   logic wr_ctrl;
   logic is16;
   logic tick;
   logic half_hi;
   logic end_a;
   logic end_b;
   logic load_a;
   logic load_b;
   logic [5:0] div_last;
   logic sd_a;
   logic sd_b;

   assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

   // mode decode: which modes carry 16-bit words
   always_comb begin
      unique case (ctrl_r.mode) // R1 R15
         MODE_SINGLE16, MODE_DUAL16, MODE_SD_NRZ, MODE_SD_RZ: is16 = 1'b1;
         default: is16 = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      vis0_nxt = vis0_r;
      vis1_nxt = vis1_r;
      hold0_nxt = hold0_r;
      hold1_nxt = hold1_r;
      rdata_nxt = 8'h00;
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL: ctrl_nxt = dpd_ctrl_t'(reg_wdata); // R2 R15
            ADDR_CH0_LO: begin
               if (is16) begin
                  hold0_nxt = reg_wdata; // R4
               end else begin
                  vis0_nxt.lo = reg_wdata;
               end
            end
            ADDR_CH0_HI: begin
               vis0_nxt.hi = reg_wdata; // R5
               if (is16) begin
                  vis0_nxt.lo = hold0_r; // R5 R6
               end
            end
            ADDR_CH1_LO: begin
               if (is16) begin
                  hold1_nxt = reg_wdata; // R4
               end else begin
                  vis1_nxt.lo = reg_wdata;
               end
            end
            ADDR_CH1_HI: begin
               vis1_nxt.hi = reg_wdata; // R5
               if (is16) begin
                  vis1_nxt.lo = hold1_r; // R5 R6
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: rdata_nxt = 8'(ctrl_r);
            ADDR_CH0_LO: rdata_nxt = vis0_r.lo;
            ADDR_CH0_HI: rdata_nxt = vis0_r.hi;
            ADDR_CH1_LO: rdata_nxt = vis1_r.lo;
            ADDR_CH1_HI: rdata_nxt = vis1_r.hi;
            ADDR_STATUS: rdata_nxt = {5'h00, oe_r, out_b_r, out_a_r};
            ADDR_COUNT: rdata_nxt = cnt_a_r[7:0];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= dpd_ctrl_t'(CTRL_RESET);
         vis0_r <= {DATA_RESET, DATA_RESET};
         vis1_r <= {DATA_RESET, DATA_RESET};
         hold0_r <= DATA_RESET;
         hold1_r <= DATA_RESET;
         rdata_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         vis0_r <= vis0_nxt;
         vis1_r <= vis1_nxt;
         hold0_r <= hold0_nxt;
         hold1_r <= hold1_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // shared divider and counters
   // ----------------------------------------------------------------
   always_comb begin
      unique case (ctrl_r.div)
         2'h0: div_last = DIV1_LAST;
         2'h1: div_last = DIV4_LAST;
         2'h2: div_last = DIV16_LAST;
         default: div_last = DIV64_LAST;
      endcase
   end

   // one divider for both outputs
   assign tick = (presc_r == div_last); // R13
   // with divide-by-1 there is no half tick, so return-to-zero degrades to full ones
   assign half_hi = (presc_r <= (div_last >> 1)); // R9 R10

   always_comb begin
      unique case (ctrl_r.mode)
         MODE_SINGLE16: end_a = (cnt_a_r == act0_r);
         MODE_DUAL8: end_a = (cnt_a_r[7:0] == BYTE_LAST);
         MODE_INDEP8: end_a = (cnt_a_r[7:0] == act1_r.lo); // R12
         default: end_a = (cnt_a_r == WORD_LAST);
      endcase
   end
   assign end_b = (cnt_b_r == act1_r.hi); // R12

   // cycle boundaries; a control write also reloads so the new mode starts clean
   assign load_a = wr_ctrl || (tick && end_a); // R16
   assign load_b = wr_ctrl || (tick && end_b);

   always_comb begin
      presc_nxt = presc_r;
      cnt_a_nxt = cnt_a_r;
      cnt_b_nxt = cnt_b_r;
      if (wr_ctrl) begin
         presc_nxt = 6'h00; // R3
         cnt_a_nxt = 16'h0000; // R3
         cnt_b_nxt = 8'h00; // R3
      end else if (tick) begin
         presc_nxt = 6'h00;
         cnt_a_nxt = end_a ? 16'h0000 : cnt_a_r + 16'h0001; // R16
         cnt_b_nxt = end_b ? 8'h00 : cnt_b_r + 8'h01; // R7
      end else begin
         presc_nxt = presc_r + 6'h01;
      end
   end

   // active words change only at a cycle boundary
   always_comb begin
      act0_nxt = act0_r;
      act1_nxt = act1_r;
      if (load_a) begin
         act0_nxt.lo = vis0_r.lo; // R5
         act1_nxt.lo = vis1_r.lo;
         if (ctrl_r.mode != MODE_INDEP8) begin
            act0_nxt.hi = vis0_r.hi;
            act1_nxt.hi = vis1_r.hi;
         end
      end
      if (load_b && ctrl_r.mode == MODE_INDEP8) begin
         act0_nxt.hi = vis0_r.hi; // R12
         act1_nxt.hi = vis1_r.hi;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_r <= 6'h00;
         cnt_a_r <= 16'h0000;
         cnt_b_r <= 8'h00;
         act0_r <= {DATA_RESET, DATA_RESET};
         act1_r <= {DATA_RESET, DATA_RESET};
      end else begin
         presc_r <= presc_nxt;
         cnt_a_r <= cnt_a_nxt;
         cnt_b_r <= cnt_b_nxt;
         act0_r <= act0_nxt;
         act1_r <= act1_nxt;
      end
   end

   // ----------------------------------------------------------------
   // sigma-delta channels
   // ----------------------------------------------------------------
   dpd_sd_chan u_sd_a (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .clear(wr_ctrl),
      .value(act0_r),
      .bit_out(sd_a)
   );

   dpd_sd_chan u_sd_b (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .clear(wr_ctrl),
      .value(act1_r),
      .bit_out(sd_b)
   );

   // ----------------------------------------------------------------
   // output shaping
   // ----------------------------------------------------------------
   always_comb begin
      out_a_nxt = 1'b0;
      out_b_nxt = 1'b0;
      oe_nxt = (ctrl_r.mode != MODE_DISABLED); // R14
      unique case (ctrl_r.mode)
         MODE_OFF: ;
         MODE_SINGLE16: out_a_nxt = (cnt_a_r < act1_r);
         MODE_DUAL8: begin
            out_a_nxt = (cnt_a_r[7:0] < act0_r.lo);
            out_b_nxt = (cnt_a_r[7:0] < act1_r.lo);
         end
         MODE_DUAL16: begin
            out_a_nxt = (cnt_a_r < act0_r); // R2
            out_b_nxt = (cnt_a_r < act1_r); // R2
         end
         MODE_SD_NRZ: begin
            out_a_nxt = sd_a; // R8
            out_b_nxt = sd_b; // R8
         end
         MODE_INDEP8: begin
            out_a_nxt = (cnt_a_r[7:0] < act0_r.lo); // R7 R12
            out_b_nxt = (cnt_b_r < act0_r.hi); // R7 R12
         end
         MODE_SD_RZ: begin
            out_a_nxt = sd_a && half_hi; // R8 R10
            out_b_nxt = sd_b && half_hi; // R8 R10
         end
         MODE_DISABLED: ; // R14
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_a_r <= 1'b0;
         out_b_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         out_a_r <= out_a_nxt;
         out_b_r <= out_b_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign out_a = out_a_r;
   assign out_b = out_b_r;
   assign out_a_oe = oe_r;
   assign out_b_oe = oe_r;
   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_ctrl_restart;
      wr_ctrl |=> (presc_r == 6'h00) && (cnt_a_r == 16'h0000) && (cnt_b_r == 8'h00);
   endproperty
   a_ctrl_restart: assert property (p_ctrl_restart) // R3
      else $error("counter not restarted by control write");

   property p_lo_hidden;
      (reg_wr && reg_addr == ADDR_CH0_LO && is16) |=> (vis0_r == $past(vis0_r))
         && (hold0_r == $past(reg_wdata));
   endproperty
   a_lo_hidden: assert property (p_lo_hidden) // R4
      else $error("low byte write leaked into visible word");

   property p_hi_pair;
      (reg_wr && reg_addr == ADDR_CH1_HI && is16) |=>
         (vis1_r == {$past(reg_wdata), $past(hold1_r)});
   endproperty
   a_hi_pair: assert property (p_hi_pair) // R5
      else $error("high byte write did not pair with held low byte");

   property p_act_hold;
      !load_a |=> (act0_r.lo == $past(act0_r.lo)) && (act1_r.lo == $past(act1_r.lo));
   endproperty
   a_act_hold: assert property (p_act_hold) // R5
      else $error("active word changed inside a cycle");

   property p_disabled;
      (ctrl_r.mode == MODE_DISABLED) |=> !out_a_oe && !out_b_oe && !out_a;
   endproperty
   a_disabled: assert property (p_disabled) // R14
      else $error("pins still driven in disabled mode");

   property p_rz_low;
      (ctrl_r.mode == MODE_SD_RZ && !half_hi && !wr_ctrl) |=> !out_a && !out_b;
   endproperty
   a_rz_low: assert property (p_rz_low) // R10
      else $error("return-to-zero output high in second half");

   property p_indep_a;
      (ctrl_r.mode == MODE_INDEP8 && !wr_ctrl && cnt_a_r[7:0] >= act0_r.lo) |=> !out_a;
   endproperty
   a_indep_a: assert property (p_indep_a) // R7
      else $error("mode 5 output a high past its duty");

   // a control write inside the window restarts the prescaler, so it ends the check
   property p_div4;
      (tick && !wr_ctrl && ctrl_r.div == 2'h1) ##1 (!wr_ctrl) [*3] |->
         (!tick && !$past(tick) && !$past(tick, 2)) ##1 tick;
   endproperty
   a_div4: assert property (p_div4) // R13
      else $error("divide-by-4 tick spacing wrong");

   property p_nrz;
      (ctrl_r.mode == MODE_SD_NRZ && !wr_ctrl) |=> (out_a == $past(sd_a));
   endproperty
   a_nrz: assert property (p_nrz) // R8
      else $error("nrz output does not follow bitstream");

   property p_dual16;
      (ctrl_r.mode == MODE_DUAL16 && !wr_ctrl) |=> (out_b == $past(cnt_a_r < act1_r));
   endproperty
   a_dual16: assert property (p_dual16) // R2
      else $error("dual 16-bit duty compare wrong");

   c_rz_pulse: cover property (ctrl_r.mode == MODE_SD_RZ ##1 $rose(out_a));
   c_hi_write: cover property (reg_wr && reg_addr == ADDR_CH0_HI && is16);
   c_wrap_b: cover property (ctrl_r.mode == MODE_INDEP8 && tick && end_b);
   c_wrap_a: cover property (ctrl_r.mode == MODE_DUAL16 && tick && end_a);

endmodule
`default_nettype wire

// ### tb/dpd_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpd_load_model (
   // clock
   input wire logic clk,
   // modulator pins
   input wire logic out_a,
   input wire logic out_a_oe,
   input wire logic out_b,
   input wire logic out_b_oe,
   // measurement window
   input wire logic start,
   input wire logic [17:0] span,
   output logic done,
   output logic [17:0] high_a,
   output logic [17:0] high_b
);
   // ----------------------------------------------------------------
   // pin level with pull-up
   // ----------------------------------------------------------------
   // a released pin floats to the pull-up, so a leaked drive shows as low
   logic pin_a;
   logic pin_b;
   logic [17:0] left_r;
   assign pin_a = out_a_oe ? out_a : 1'b1;
   assign pin_b = out_b_oe ? out_b : 1'b1;

   // ----------------------------------------------------------------
   // filter stand-in: counts high cycles over a window
   // ----------------------------------------------------------------
   // high-cycle count is what an rc filter averages, so it is the figure judged
   initial begin
      done = 1'b0;
      left_r = 18'h00000;
      high_a = 18'h00000;
      high_b = 18'h00000;
   end
   always @(posedge clk) begin
      done <= 1'b0;
      if (start) begin
         left_r <= span;
         high_a <= 18'h00000;
         high_b <= 18'h00000;
      end else if (left_r != 18'h00000) begin
         high_a <= high_a + {17'h00000, pin_a};
         high_b <= high_b + {17'h00000, pin_b};
         left_r <= left_r - 18'h00001;
         if (left_r == 18'h00001) begin
            done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import dpd_pkg::*;
;
   typedef struct {
      string name;
      logic [17:0] exp;
   } dpd_tb_note_t;

   logic clk;
   logic rst_n;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic out_a;
   logic out_a_oe;
   logic out_b;
   logic out_b_oe;
   logic start;
   logic [17:0] span;
   logic done;
   logic [17:0] high_a;
   logic [17:0] high_b;
   logic rd_d;
   int errors;
   int samples_checked;
   int seed;
   logic [7:0] rnd [4];
   dpd_tb_note_t notes [$];
   dpd_tb_note_t n;

   dpd_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_a(out_a),
      .out_a_oe(out_a_oe), .out_b(out_b), .out_b_oe(out_b_oe));
   dpd_load_model load (.clk(clk), .out_a(out_a), .out_a_oe(out_a_oe), .out_b(out_b),
      .out_b_oe(out_b_oe), .start(start), .span(span), .done(done), .high_a(high_a),
      .high_b(high_b));

   // ----------------------------------------------------------------
   // clock, comparison and closing
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // monitor: oldest note against each result that appears
   // ----------------------------------------------------------------
   // reads answer only in the cycle after the strobe, so that cycle is the one looked at
   always @(posedge clk) begin
      if (rd_d === 1'b1) begin
         n = notes.pop_front();
         check(n.name, {10'h000, reg_rdata}, n.exp);
      end
      if (done === 1'b1) begin
         n = notes.pop_front();
         check(n.name, high_a, n.exp);
         n = notes.pop_front();
         check(n.name, high_b, n.exp);
      end
      rd_d <= reg_rd;
   end

   // ----------------------------------------------------------------
   // register port driver
   // ----------------------------------------------------------------
   // each call sets both strobes once, so back-to-back accesses never double-assign
   task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, a, d);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string name);
      notes.push_back('{name, {10'h000, e}});
      acc(1'b0, 1'b1, a, 8'h00);
   endtask

   task automatic measure(input logic [17:0] len, input logic [17:0] ea, input logic [17:0] eb);
      int i;
      acc(1'b0, 1'b0, 3'h0, 8'h00);
      notes.push_back('{"high cycles a", ea});
      notes.push_back('{"high cycles b", eb});
      span <= len;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < len + 8 && done !== 1'b1; i++) begin
         @(posedge clk);
      end
      @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      #(25 * 20000);
      errors++;
      close_out();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      start = 1'b0;
      span = 18'h00000;
      rd_d = 1'b0;
      errors = 0;
      samples_checked = 0;
      seed = 32'h18C3;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
      for (int k = 1; k <= 4; k++) begin
         rd(k[2:0], DATA_RESET, "data reset");
      end
      rd(ADDR_STATUS, 8'h00, "status reset");
      rd(3'h7, 8'h00, "unmapped read");
      measure(18'h00032, 18'h00032, 18'h00032);
      // dual 8-bit: random duties, direct byte writes
      for (int k = 0; k < 4; k++) begin
         rnd[k] = 8'($random(seed));
      end
      wr(ADDR_CTRL, 8'h02);
      for (int k = 0; k < 4; k++) begin
         wr(k[2:0] + 3'h1, rnd[k]);
      end
      for (int k = 0; k < 4; k++) begin
         rd(k[2:0] + 3'h1, rnd[k], "data readback");
      end
      wr(ADDR_CTRL, 8'h02);
      measure(18'h00200, {9'h000, rnd[0], 1'b0}, {9'h000, rnd[2], 1'b0});
      // counter restart on a control write, slow divider keeps it at zero
      wr(ADDR_CTRL, 8'h1A);
      rd(ADDR_COUNT, 8'h00, "counter after ctrl write");
      rd(ADDR_CTRL, 8'h1A, "ctrl readback");
      // independent mode: periods from channel 1, duties from channel 0
      wr(ADDR_CTRL, 8'h05);
      wr(ADDR_CH0_LO, 8'h03);
      wr(ADDR_CH0_HI, 8'h02);
      wr(ADDR_CH1_LO, 8'h09);
      wr(ADDR_CH1_HI, 8'h04);
      wr(ADDR_CTRL, 8'h05);
      measure(18'h00064, 18'h0001E, 18'h00028);
      // dual 16-bit then single 16-bit on the same words: duties 9 and 4, then period 9+1 with duty 4
      wr(ADDR_CTRL, 8'h03);
      wr(ADDR_CH0_LO, 8'h09);
      wr(ADDR_CH0_HI, 8'h00);
      wr(ADDR_CH1_LO, 8'h04);
      wr(ADDR_CH1_HI, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      measure(18'h00020, 18'h00008, 18'h00003);
      wr(ADDR_CTRL, 8'h01);
      measure(18'h00064, 18'h00028, 18'h00000);
      // 16-bit sigma-delta: held low byte, paired high byte, deferred effect
      wr(ADDR_CTRL, 8'h00);
      measure(18'h00032, 18'h00000, 18'h00000);
      wr(ADDR_CH0_LO, 8'h00);
      wr(ADDR_CH0_HI, 8'h00);
      wr(ADDR_CH1_LO, 8'h00);
      wr(ADDR_CH1_HI, 8'h00);
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_CH1_LO, 8'h5A);
      rd(ADDR_CH1_LO, 8'h00, "low byte held");
      wr(ADDR_CH1_HI, 8'h41);
      // low bits 0...01 for a quicker 8-bit accurate stream
      wr(ADDR_CH0_LO, 8'h01);
      wr(ADDR_CH0_HI, 8'h41);
      rd(ADDR_CH1_HI, 8'h41, "high byte");
      rd(ADDR_CH1_LO, 8'h5A, "low byte paired");
      measure(18'h00100, 18'h00000, 18'h00000);
      wr(ADDR_CTRL, 8'h04);
      measure(18'h00100, 18'h00041, 18'h00041);
      // return-to-zero with divide by 4: two high clocks per one
      wr(ADDR_CTRL, 8'h0E);
      // window sees 64 whole ones plus the first half of one more on a, 65 whole ones on b
      measure(18'h00400, 18'h00081, 18'h00082);
      wr(ADDR_CTRL, 8'h07);
      measure(18'h00032, 18'h00032, 18'h00032);
      close_out();
   end
endmodule
`default_nettype wire
